// File: hdl/rpc_pkg.sv
// Purpose: Shared constants for the always-on power regulator control block.
// Assumes: 16-bit registers on a 32-bit APB data path, 10 MHz clock.
// Notes:   Offsets are byte addresses; unused upper data bits read as zero.

package rpc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [15:0] RPC_ADDR_RTC_POWER_CONTROL = 16'h1930;
	localparam logic [15:0] RPC_ADDR_REGULATOR_CONTROL = 16'h7004;

	// ------------------------------------------------------------
	// Field positions of the power control register
	// ------------------------------------------------------------
	localparam int RPC_BIT_CLOCK_OUTPUT_ENABLE   = 0;
	localparam int RPC_BIT_REGULATOR_POWER_DOWN  = 1;
	localparam int RPC_BIT_FULL_POWER_DOWN       = 2;
	localparam int RPC_BIT_WAKE_PIN_DIRECTION    = 3;
	localparam int RPC_BIT_WAKE_PIN_DRIVE_LEVEL  = 4;

	// ------------------------------------------------------------
	// Field positions of the regulator control register
	// ------------------------------------------------------------
	localparam int RPC_BIT_USB_REGULATOR_ENABLE  = 0;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [4:0] RPC_RESET_POWER_CONTROL = 5'h00;
	localparam logic       RPC_RESET_USB_ENABLE    = 1'b0;

	// ------------------------------------------------------------
	// Timing: bandgap recharge time after a full power-down
	// ------------------------------------------------------------
	localparam int RPC_CLOCK_HZ          = 10000000;
	localparam int RPC_BANDGAP_SETTLE_MS = 100;
	localparam int RPC_BANDGAP_SETTLE_CYC = RPC_BANDGAP_SETTLE_MS * (RPC_CLOCK_HZ / 1000);
	localparam int RPC_SETTLE_CNT_W      = 24;

	// Power state of the regulators, one-hot.
	typedef enum logic [3:0]
	{
		RPC_ST_ON       = 4'h1,
		RPC_ST_LDO_OFF  = 4'h2,
		RPC_ST_FULL_OFF = 4'h4,
		RPC_ST_SETTLE   = 4'h8
	} rpc_state_t;

endpackage

// File: hdl/rpc_pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Input is asynchronous to clock_in.
// Notes:   The filtered level changes only when stages two and three agree.

`timescale 1ns/1ps
`default_nettype none

module rpc_pin_sync
(
	input  wire logic clock_in,  // Block clock.
	input  wire logic rst_in,    // Asynchronous reset, active high.
	input  wire logic pin_in,    // Raw pin level.
	output var  logic level_out  // Filtered synchronous level.
);

	// All state in one record.
	typedef struct packed
	{
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} rpc_sync_t;

	rpc_sync_t state_ff;
	rpc_sync_t nxt_state;

	// Shift the pin through three stages; stage one feeds only stage two.
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.s1 = pin_in;
		nxt_state.s2 = state_ff.s1;
		nxt_state.s3 = state_ff.s2;
		if (state_ff.s2 == state_ff.s3)
		begin
			nxt_state.level = state_ff.s3;
		end
	end

	// Register the record.
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign level_out = state_ff.level;

endmodule

`default_nettype wire

// File: hdl/rpc_power_ctrl.sv
// Purpose: Power-down and wake control for the on-chip regulators and bandgap.
// Assumes: APB slave with one wait state; alarm input is a same-clock pulse.
// Notes:   Hardware wake clears the power-down bits in the control register.
//
// The APB interface to the registers was decided locally.

`timescale 1ns/1ps
`default_nettype none

module rpc_power_ctrl
	import rpc_pkg::*;
#(
	parameter int SETTLE_CYCLES = RPC_BANDGAP_SETTLE_CYC  // Bandgap recharge count.
)
(
	input  wire logic        clock_in,                 // 10 MHz clock.
	input  wire logic        rst_in,                   // Asynchronous reset, active high.
	input  wire logic        psel,                     // APB select.
	input  wire logic        penable,                  // APB access phase.
	input  wire logic        pwrite,                   // APB write direction.
	input  wire logic [15:0] paddr,                    // APB byte address.
	input  wire logic [31:0] pwdata,                   // APB write data.
	output var  logic [31:0] prdata,                   // APB read data.
	output var  logic        pready,                   // APB ready.
	output var  logic        pslverr,                  // APB error on unmapped address.
	input  wire logic        wake_pin_in,              // Wake pin level.
	output var  logic        wake_pin_out,             // Wake pin drive value, always low.
	output var  logic        wake_pin_oe_out,          // Wake pin driven low when high.
	input  wire logic        rtc_alarm_in,             // Alarm pulse from the clock.
	output var  logic        clock_output_enable_out,  // Clock output pin gate.
	output var  logic        analog_regulator_on_out,  // Analog regulator enable.
	output var  logic        usb_regulator_on_out,     // USB regulator enable.
	output var  logic        usb_regulator_output_en_out, // USB output not floating.
	output var  logic        analog_por_on_out,        // Analog power-on reset enable.
	output var  logic        bandgap_on_out,           // Bandgap reference enable.
	output var  logic        references_ready_out      // Bandgap recharged.
);

	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << RPC_SETTLE_CNT_W))
	begin : g_bad_settle
		$error("SETTLE_CYCLES out of range for the settle counter");
	end

	localparam logic [RPC_SETTLE_CNT_W-1:0] SETTLE_LAST =
		RPC_SETTLE_CNT_W'(SETTLE_CYCLES - 1);

	// ------------------------------------------------------------
	// State record
	// ------------------------------------------------------------
	typedef struct packed
	{
		logic [4:0]                  pwr;      // Power control bits 4:0.
		logic                        usb_en;   // USB regulator enable.
		rpc_state_t                  fsm;
		logic [RPC_SETTLE_CNT_W-1:0] cnt;
		logic [31:0]                 rdata;
		logic                        ready;
		logic                        err;
		logic                        wake_oe;
		logic                        clk_en;
		logic                        ana_on;
		logic                        usb_on;
		logic                        por_on;
		logic                        bg_on;
		logic                        ref_ok;
	} rpc_ctrl_t;

	rpc_ctrl_t state_ff;
	rpc_ctrl_t nxt_state;

	logic wake_level;
	logic access;
	logic hit_pwr;
	logic hit_ldo;
	logic pin_wake;
	logic wake_evt;

	// ------------------------------------------------------------
	// Wake pin synchroniser
	// ------------------------------------------------------------
	rpc_pin_sync u_wake_sync
	(
		.clock_in  (clock_in),
		.rst_in    (rst_in),
		.pin_in    (wake_pin_in),
		.level_out (wake_level)
	);

	// Bus decode and wake event qualification.
	assign access   = psel && penable && state_ff.ready;
	assign hit_pwr  = (paddr == RPC_ADDR_RTC_POWER_CONTROL);
	assign hit_ldo  = (paddr == RPC_ADDR_REGULATOR_CONTROL);
	assign pin_wake = wake_level && !state_ff.pwr[RPC_BIT_WAKE_PIN_DIRECTION];
	assign wake_evt = pin_wake || rtc_alarm_in;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	// Bus slave, register writes, wake sequencing and output decode.
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.ready = psel && penable && !state_ff.ready;
		nxt_state.err = 1'b0;
		nxt_state.rdata = '0;
		// A transfer completes on the edge where pready is seen high.
		if (psel && penable && !state_ff.ready)
		begin
			nxt_state.err = !(hit_pwr || hit_ldo);
			if (!pwrite && hit_pwr)
			begin
				nxt_state.rdata = {27'h0000000, state_ff.pwr};
			end
			else if (!pwrite && hit_ldo)
			begin
				nxt_state.rdata = {31'h00000000, state_ff.usb_en};
			end
		end
		if (access && pwrite && hit_pwr)
		begin
			nxt_state.pwr = pwdata[4:0];
		end
		if (access && pwrite && hit_ldo)
		begin
			nxt_state.usb_en = pwdata[RPC_BIT_USB_REGULATOR_ENABLE];
		end
		// Power state machine; a wake in a powered-down state beats a write.
		case (state_ff.fsm)
			RPC_ST_ON, RPC_ST_SETTLE:
			begin
				if (state_ff.fsm == RPC_ST_SETTLE)
				begin
					nxt_state.cnt = state_ff.cnt + 1'b1;
					if (state_ff.cnt == SETTLE_LAST)
					begin
						nxt_state.fsm = RPC_ST_ON;
					end
				end
				if (nxt_state.pwr[RPC_BIT_FULL_POWER_DOWN])
				begin
					nxt_state.fsm = RPC_ST_FULL_OFF;
				end
				else if (nxt_state.pwr[RPC_BIT_REGULATOR_POWER_DOWN])
				begin
					nxt_state.fsm = RPC_ST_LDO_OFF;
				end
			end
			RPC_ST_LDO_OFF:
			begin
				if (wake_evt)
				begin
					nxt_state.pwr[RPC_BIT_REGULATOR_POWER_DOWN] = 1'b0;
					nxt_state.pwr[RPC_BIT_FULL_POWER_DOWN] = 1'b0;
					nxt_state.fsm = RPC_ST_ON;
				end
				else if (nxt_state.pwr[RPC_BIT_FULL_POWER_DOWN])
				begin
					nxt_state.fsm = RPC_ST_FULL_OFF;
				end
				else if (!nxt_state.pwr[RPC_BIT_REGULATOR_POWER_DOWN])
				begin
					nxt_state.fsm = RPC_ST_ON;
				end
			end
			RPC_ST_FULL_OFF:
			begin
				if (wake_evt || !nxt_state.pwr[RPC_BIT_FULL_POWER_DOWN])
				begin
					if (wake_evt)
					begin
						nxt_state.pwr[RPC_BIT_REGULATOR_POWER_DOWN] = 1'b0;
						nxt_state.pwr[RPC_BIT_FULL_POWER_DOWN] = 1'b0;
					end
					nxt_state.cnt = '0;
					nxt_state.fsm = RPC_ST_SETTLE;
					if (nxt_state.pwr[RPC_BIT_REGULATOR_POWER_DOWN])
					begin
						nxt_state.fsm = RPC_ST_LDO_OFF;
					end
				end
			end
			default:
			begin
				nxt_state.fsm = RPC_ST_ON;
			end
		endcase
		// Outputs follow the next register values so they leave flip-flops.
		nxt_state.wake_oe = nxt_state.pwr[RPC_BIT_WAKE_PIN_DIRECTION] &&
			!nxt_state.pwr[RPC_BIT_WAKE_PIN_DRIVE_LEVEL];
		nxt_state.clk_en = nxt_state.pwr[RPC_BIT_CLOCK_OUTPUT_ENABLE];
		nxt_state.ana_on = (nxt_state.fsm == RPC_ST_ON) ||
			(nxt_state.fsm == RPC_ST_SETTLE);
		nxt_state.por_on = nxt_state.ana_on;
		nxt_state.usb_on = nxt_state.ana_on && nxt_state.usb_en;
		nxt_state.bg_on = (nxt_state.fsm != RPC_ST_FULL_OFF);
		nxt_state.ref_ok = nxt_state.bg_on && (nxt_state.fsm != RPC_ST_SETTLE);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	// Everything resets to the powered, disabled-output condition.
	always_ff @(posedge clock_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_ff        <= '0;
			state_ff.pwr    <= RPC_RESET_POWER_CONTROL;
			state_ff.usb_en <= RPC_RESET_USB_ENABLE;
			state_ff.fsm    <= RPC_ST_ON;
			state_ff.ana_on <= 1'b1;
			state_ff.por_on <= 1'b1;
			state_ff.bg_on  <= 1'b1;
			state_ff.ref_ok <= 1'b1;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// Port assignments straight from the record, except the constant-low wake drive.
	assign prdata                      = state_ff.rdata;
	assign pready                      = state_ff.ready;
	assign pslverr                     = state_ff.err;
	assign wake_pin_out                = 1'b0;
	assign wake_pin_oe_out             = state_ff.wake_oe;
	assign clock_output_enable_out     = state_ff.clk_en;
	assign analog_regulator_on_out     = state_ff.ana_on;
	assign usb_regulator_on_out        = state_ff.usb_on;
	assign usb_regulator_output_en_out = state_ff.usb_on;
	assign analog_por_on_out           = state_ff.por_on;
	assign bandgap_on_out              = state_ff.bg_on;
	assign references_ready_out        = state_ff.ref_ok;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	AST_PWR_RSVD_READ: assert property (
		(psel && penable && !pready && !pwrite && hit_pwr) |=> (prdata[31:5] == 27'h0))
		else $error("Reserved power control bits read nonzero");
	AST_LDO_RSVD_READ: assert property (
		(psel && penable && !pready && !pwrite && hit_ldo) |=> (prdata[31:1] == 31'h0))
		else $error("Reserved regulator control bits read nonzero");
	AST_WAKE_DRIVE: assert property (
		wake_pin_oe_out == (state_ff.pwr[3] && !state_ff.pwr[4]))
		else $error("Wake pin enable disagrees with direction and level");
	AST_WAKE_OUT_ONLY: assert property (
		(state_ff.fsm == RPC_ST_LDO_OFF && state_ff.pwr[3] && !rtc_alarm_in && !access)
		|=> state_ff.fsm == RPC_ST_LDO_OFF)
		else $error("Wake pin woke the device while configured as output");
	AST_FULL_OFF: assert property (
		state_ff.pwr[2] |-> !bandgap_on_out && !analog_regulator_on_out && !analog_por_on_out)
		else $error("Full power-down left a supply on");
	AST_LDO_OFF: assert property (
		(state_ff.pwr[1] && !state_ff.pwr[2]) |-> bandgap_on_out && !analog_por_on_out)
		else $error("Regulator power-down state wrong");
	AST_FULL_WAKE: assert property (
		(state_ff.fsm == RPC_ST_FULL_OFF && rtc_alarm_in)
		|=> bandgap_on_out && analog_regulator_on_out && !references_ready_out)
		else $error("Alarm did not restore supplies after full power-down");
	AST_LDO_WAKE: assert property (
		(state_ff.fsm == RPC_ST_LDO_OFF && rtc_alarm_in) |=> analog_por_on_out ##1 analog_por_on_out)
		else $error("Alarm did not restore regulators");
	AST_CLKOUT: assert property (
		$rose(state_ff.pwr[0]) |-> clock_output_enable_out)
		else $error("Clock output gate does not follow its bit");
	AST_USB: assert property (
		usb_regulator_on_out == (state_ff.usb_en && !state_ff.pwr[1] && !state_ff.pwr[2]))
		else $error("USB regulator state wrong");

	// A cleared enable must float the USB regulator output.
	AST_USB_FLOAT: assert property (
		!state_ff.usb_en |-> !usb_regulator_output_en_out)
		else $error("USB regulator output driven while disabled");

	// References are not reported ready while the bandgap recharges.
	AST_REFS_SETTLE: assert property (
		(state_ff.fsm == RPC_ST_SETTLE) |-> !references_ready_out)
		else $error("References ready during bandgap recharge");

	// A high input-mode wake pin ends a regulator power-down.
	AST_PIN_WAKE: assert property (
		(state_ff.fsm == RPC_ST_LDO_OFF && pin_wake) |=> (state_ff.fsm == RPC_ST_ON))
		else $error("Wake pin did not restore regulators");

	// An unmapped access answers with an error and zero data.
	AST_UNMAPPED: assert property (
		(psel && penable && !pready && !(hit_pwr || hit_ldo)) |=> (pslverr && prdata == 32'h0))
		else $error("Unmapped access not refused");

endmodule

`default_nettype wire

// File: dv/rpc_wake_source.sv
// Purpose: Board-side model of the wake line with its external pull-up.
// Assumes: The bench commands the source; the device pulls the line low.
// Notes:   Pull-up wins only when neither party drives the line.

`timescale 1ns/1ps
`default_nettype none

module rpc_wake_source
(
	input  wire logic drive_high_in, // Source level while it drives the line.
	input  wire logic release_in,    // Source lets go of the line.
	input  wire logic dev_oe_in,     // Device pulls the line low.
	output var  logic line_out       // Resolved wire level.
);
	// Open-drain low wins, then the driving source, else the pull-up.
	always_comb
	begin
		if (dev_oe_in)
			line_out = 1'b0;
		else if (release_in)
			line_out = 1'b1;
		else
			line_out = drive_high_in;
	end
endmodule

`default_nettype wire

// File: dv/rpc_power_ctrl_test.sv
// Purpose: Self-checking bench for the regulator power control block.
// Assumes: Settle count shortened to 20 cycles; regulators never bypassed.
// Notes:   Pin outputs other than wake_drv are packed into one vector so one compare covers them.

`timescale 1ns/1ps
`default_nettype none

module rpc_power_ctrl_test;
	import rpc_pkg::*;
	logic        clock_in, rst_in, psel, penable, pwrite, pready, pslverr;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        wake_line, wake_drv, wake_oe, alarm, src_high, src_rel;
	logic        clk_en, ana_on, usb_on, usb_oe, por_on, bg_on, refs;
	int          err_count, check_count, cyc;

	rpc_power_ctrl #(.SETTLE_CYCLES(20)) i_rpc_power_ctrl (.clock_in(clock_in),
		.rst_in(rst_in), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wake_pin_in(wake_line), .wake_pin_out(wake_drv), .wake_pin_oe_out(wake_oe),
		.rtc_alarm_in(alarm), .clock_output_enable_out(clk_en),
		.analog_regulator_on_out(ana_on), .usb_regulator_on_out(usb_on),
		.usb_regulator_output_en_out(usb_oe), .analog_por_on_out(por_on),
		.bandgap_on_out(bg_on), .references_ready_out(refs));

	rpc_wake_source i_rpc_wake_source (.drive_high_in(src_high), .release_in(src_rel),
		.dev_oe_in(wake_oe), .line_out(wake_line));

	// ------------------------------------------------------------
	// Clock and hang guard
	// ------------------------------------------------------------
	initial
	begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end

	// A run that outlives the planned sequence counts as a mismatch.
	always @(posedge clock_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_count = err_count + 1;
			close_out();
		end
	end

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic close_out();
		if (err_count == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count = check_count + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
		end
	endtask

	// Pin vector: analog, por, bandgap, refs, usb, usb out, clock out, oe, line.
	// Sampled at the falling edge, where the registered outputs have settled.
	task automatic chk_out(input logic [8:0] exp);
		@(negedge clock_in);
		check_count = check_count + 1;
		if ({ana_on, por_on, bg_on, refs, usb_on, usb_oe, clk_en, wake_oe, wake_line} !== exp)
		begin
			err_count = err_count + 1;
			$display("CHECK FAILED %0t pins differ from %h", $time, exp);
		end
		@(posedge clock_in);
	endtask

	// One APB transfer; request held until pready is sampled high.
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_in);
		penable <= 1'b1;
		// Look at pready where it has settled; it is sampled at the next rise.
		@(negedge clock_in);
		while (pready !== 1'b1 && n < 20)
		begin
			@(negedge clock_in);
			n++;
		end
		if (n >= 20)
		begin
			err_count = err_count + 1;
			$display("CHECK FAILED %0t no bus answer", $time);
		end
		r = prdata;
		e = pslverr;
		@(posedge clock_in);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock_in);
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk_word(r, exp);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock_in);
	endtask

	// Waits, bounded, for the regulators to come back after a wake.
	task automatic wait_on();
		int n;
		n = 0;
		@(negedge clock_in);
		while (ana_on !== 1'b1 && n < 40)
		begin
			@(negedge clock_in);
			n++;
		end
		if (n >= 40)
		begin
			err_count = err_count + 1;
			$display("CHECK FAILED %0t regulators did not return", $time);
		end
		@(posedge clock_in);
	endtask

	// ------------------------------------------------------------
	// Main sequence; power-down is only used with internal regulators.
	// ------------------------------------------------------------
	initial
	begin : main_seq
		logic [31:0] r;
		logic        e;
		err_count = 0;
		check_count = 0;
		rst_in = 1'b1;
		{psel, penable, pwrite, alarm, src_high, src_rel} = 6'h00;
		paddr = 16'h0000;
		pwdata = 32'h0;
		idle(8);
		rst_in <= 1'b0;
		idle(1);
		chk_out(9'h1E0);
		rd(RPC_ADDR_RTC_POWER_CONTROL, 32'h0);
		rd(RPC_ADDR_REGULATOR_CONTROL, 32'h0);
		wr(RPC_ADDR_RTC_POWER_CONTROL, 32'h0000FFE1);
		rd(RPC_ADDR_RTC_POWER_CONTROL, 32'h1);
		idle(2);
		chk_out(9'h1E4);
		wr(RPC_ADDR_REGULATOR_CONTROL, 32'h0000FFFF);
		rd(RPC_ADDR_REGULATOR_CONTROL, 32'h1);
		idle(2);
		chk_out(9'h1FC);
		wr(RPC_ADDR_REGULATOR_CONTROL, 32'h0);
		wr(RPC_ADDR_RTC_POWER_CONTROL, 32'h08);
		idle(2);
		chk_out(9'h1E2);
		chk_word({31'h0, wake_drv}, 32'h0);
		apb(1'b0, 16'h1934, 32'h0, r, e);
		chk_word({e, r[30:0]}, 32'h80000000);
		// Pin released high while it is an output must not wake.
		src_rel <= 1'b1;
		wr(RPC_ADDR_RTC_POWER_CONTROL, 32'h18);
		idle(2);
		chk_out(9'h1E1);
		wr(RPC_ADDR_RTC_POWER_CONTROL, 32'h1A);
		idle(10);
		chk_out(9'h061);
		rd(RPC_ADDR_RTC_POWER_CONTROL, 32'h1A);
		wr(RPC_ADDR_RTC_POWER_CONTROL, 32'h02);
		wait_on();
		idle(2);
		chk_out(9'h1E1);
		rd(RPC_ADDR_RTC_POWER_CONTROL, 32'h0);
		// Full power-down with the line low, then an alarm wake.
		src_rel <= 1'b0;
		wr(RPC_ADDR_REGULATOR_CONTROL, 32'h1);
		wr(RPC_ADDR_RTC_POWER_CONTROL, 32'h04);
		idle(10);
		chk_out(9'h000);
		alarm <= 1'b1;
		idle(1);
		alarm <= 1'b0;
		wait_on();
		idle(1);
		chk_out(9'h1D8);
		idle(30);
		chk_out(9'h1F8);
		rd(RPC_ADDR_RTC_POWER_CONTROL, 32'h0);
		close_out();
	end
endmodule

`default_nettype wire
